// ==== rtl/video_forwarding_config_regs.sv ====
// Our own choice: the address-and-strobe port.
module video_forwarding_config_regs
  import vfc_pkg::*;
(
  input  wire logic                  clock,
  input  wire logic                  srst,
  input  wire logic [ADDR_W-1:0]     regAddr,
  input  wire logic [DATA_W-1:0]     regWriteData,
  input  wire logic                  regWrite,
  input  wire logic                  regRead,
  output logic      [DATA_W-1:0]     regReadData,
  input  wire logic                  syncEnable,
  input  wire logic                  syncEqualDuty,
  input  wire logic                  rawMode,
  input  wire logic                  frameStart,
  input  wire logic                  frameEnd,
  input  wire logic [NUM_INPUTS-1:0] inputValid,
  output logic      [15:0]           frameNumber,
  output logic                       inFrame,
  output logic                       syncPulse,
  output logic                       internalOscillatorSelect,
  output logic                       referenceHalfRate,
  output logic      [1:0]            laneRate,
  output logic      [NUM_INPUTS-1:0] forwardOut0,
  output logic      [NUM_INPUTS-1:0] forwardOut1
);
  logic [7:0]  syncHighLsb;
  logic [7:0]  syncLowMsb;
  logic [7:0]  syncLowPeriodLsb;
  logic [7:0]  frameCountLimitMsb;
  logic [7:0]  frameCountLimitLsb;
  logic [7:0]  outputClockControl;
  logic [7:0]  inputForwardControl;
  logic [15:0] frameLimit;
  logic [15:0] counterNumber;
  logic        counterInFrame;
  logic        timerPulse;
  logic [7:0]  next_readData;

  always_ff @(posedge clock) begin
    if (srst) begin
      syncHighLsb <= RST_SYNC_HIGH_LSB;
    end else if (regWrite && regAddr == ADDR_SYNC_HIGH_LSB) begin
      syncHighLsb <= regWriteData;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      syncLowMsb <= RST_SYNC_LOW_MSB;
    end else if (regWrite && regAddr == ADDR_SYNC_LOW_MSB) begin
      syncLowMsb <= regWriteData; // RL3
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      syncLowPeriodLsb <= RST_SYNC_LOW_LSB;
    end else if (regWrite && regAddr == ADDR_SYNC_LOW_LSB) begin
      syncLowPeriodLsb <= regWriteData; // RL1
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      frameCountLimitMsb <= RST_LIMIT_MSB;
      frameCountLimitLsb <= RST_LIMIT_LSB;
    end else if (regWrite && regAddr == ADDR_LIMIT_MSB) begin
      frameCountLimitMsb <= regWriteData;
    end else if (regWrite && regAddr == ADDR_LIMIT_LSB) begin
      frameCountLimitLsb <= regWriteData;
    end
  end

  assign frameLimit = {frameCountLimitMsb, frameCountLimitLsb}; // RL5

  // Reserved upper bits never store, so they read zero
  always_ff @(posedge clock) begin
    if (srst) begin
      outputClockControl <= RST_CLOCK_CTRL;
    end else if (regWrite && regAddr == ADDR_CLOCK_CTRL) begin
      outputClockControl <= regWriteData & CLOCK_CTRL_MASK;
    end
  end

  // Remapping a live input is not blocked; software is expected to block first
  always_ff @(posedge clock) begin
    if (srst) begin
      inputForwardControl <= RST_FORWARD_CTRL;
    end else if (regWrite && regAddr == ADDR_FORWARD_CTRL) begin
      inputForwardControl <= regWriteData; // RL16
    end
  end

  always_comb begin
    case (regAddr)
      ADDR_SYNC_HIGH_LSB: next_readData = syncHighLsb;
      ADDR_SYNC_LOW_MSB:  next_readData = syncLowMsb;
      ADDR_SYNC_LOW_LSB:  next_readData = syncLowPeriodLsb;
      ADDR_LIMIT_MSB:     next_readData = frameCountLimitMsb;
      ADDR_LIMIT_LSB:     next_readData = frameCountLimitLsb;
      ADDR_CLOCK_CTRL:    next_readData = outputClockControl;
      ADDR_FORWARD_CTRL:  next_readData = inputForwardControl;
      default:            next_readData = 8'h00;
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      regReadData <= 8'h00;
    end else if (regRead) begin
      regReadData <= next_readData;
    end else begin
      regReadData <= 8'h00;
    end
  end

  vfc_frame_counter u_counter (
    .clock       (clock),
    .srst        (srst),
    .rawMode     (rawMode),
    .frameLimit  (frameLimit),
    .frameStart  (frameStart),
    .frameEnd    (frameEnd),
    .frameNumber (counterNumber),
    .inFrame     (counterInFrame)
  );

  vfc_sync_timer u_timer (
    .clock     (clock),
    .srst      (srst),
    .enable    (syncEnable),
    .equalDuty (syncEqualDuty),
    .highLsb   (syncHighLsb),
    .lowMsb    (syncLowMsb),
    .lowLsb    (syncLowPeriodLsb),
    .syncPulse (timerPulse)
  );

  always_ff @(posedge clock) begin
    if (srst) begin
      frameNumber <= FRAME_NUM_ZERO;
      inFrame     <= 1'b0;
      syncPulse   <= 1'b0;
    end else begin
      frameNumber <= counterNumber; // RL6
      inFrame     <= counterInFrame;
      syncPulse   <= timerPulse;
    end
  end

  // Mode bit is passed as written even at 400 Mbps; guarding it is left to software
  always_ff @(posedge clock) begin
    if (srst) begin
      internalOscillatorSelect <= RST_CLOCK_CTRL[OSC_SEL_BIT];
      referenceHalfRate        <= RST_CLOCK_CTRL[REF_MODE_BIT];
      laneRate                 <= RST_CLOCK_CTRL[RATE_LSB+:2];
    end else begin
      internalOscillatorSelect <= outputClockControl[OSC_SEL_BIT]; // RL10
      referenceHalfRate        <= outputClockControl[REF_MODE_BIT]; // RL11 RL12
      laneRate                 <= outputClockControl[RATE_LSB+:2]; // RL13
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_INPUTS; gi++) begin : g_route
      always_ff @(posedge clock) begin
        if (srst) begin
          forwardOut0[gi] <= 1'b0;
          forwardOut1[gi] <= 1'b0;
        end else begin
          forwardOut0[gi] <= inputValid[gi] && !inputForwardControl[BLOCK_LSB+gi] &&
                             !inputForwardControl[ROUTE_LSB+gi]; // RL14 RL15
          forwardOut1[gi] <= inputValid[gi] && !inputForwardControl[BLOCK_LSB+gi] &&
                             inputForwardControl[ROUTE_LSB+gi]; // RL14 RL15
        end
      end
    end
  endgenerate
endmodule : video_forwarding_config_regs

// ==== inc/vfc_pkg.sv ====
// Notes on behaviour
// RL1: Low-period register holds bits 7:0 of the sync low count.
// RL2: Programmed low value is wanted cycles minus one; zero gives one cycle.
// RL3: Bits 15:8 of the low count come from a separate upper register.
// RL4: Equal-duty mode joins high low byte and both low bytes as 24 bits.
// RL5: Maximum frame count is upper byte 15:8 and lower byte 7:0.
// RL6: Raw mode frames carry a generated 16-bit frame number at start and end.
// RL7: Maximum count zero disables numbering; every frame number reads zero.
// RL8: Non-zero maximum: number counts one up to maximum, then wraps to one.
// RL9: Start and end packets of one frame share a number; advance on start.
// RL10: Clock control bit 3 picks external reference or internal oscillator.
// RL11: Logic reference is 200 MHz, or 100 MHz when mode bit is one.
// RL12: Software must not set mode bit while lane rate selects 400 Mbps.
// RL13: Two-bit lane rate: 00 fastest, 01 1.2G, 10 800M, 11 400M.
// RL14: Forward control bits 7:4 block inputs 3:0; one blocks forwarding.
// RL15: Forward control bits 3:0 route inputs 3:0 to output port 0 or 1.
// RL16: Software should block an input before changing its output mapping.
package vfc_pkg;
  localparam int          ADDR_W            = 8;
  localparam int          DATA_W            = 8;
  localparam int          NUM_INPUTS        = 4;
  localparam logic [7:0]  ADDR_SYNC_HIGH_LSB = 8'h1A;
  localparam logic [7:0]  ADDR_SYNC_LOW_MSB  = 8'h1B;
  localparam logic [7:0]  ADDR_SYNC_LOW_LSB  = 8'h1C;
  localparam logic [7:0]  ADDR_LIMIT_MSB     = 8'h1D;
  localparam logic [7:0]  ADDR_LIMIT_LSB     = 8'h1E;
  localparam logic [7:0]  ADDR_CLOCK_CTRL    = 8'h1F;
  localparam logic [7:0]  ADDR_FORWARD_CTRL  = 8'h20;
  localparam logic [7:0]  RST_SYNC_HIGH_LSB  = 8'h00;
  localparam logic [7:0]  RST_SYNC_LOW_MSB   = 8'h00;
  localparam logic [7:0]  RST_SYNC_LOW_LSB   = 8'h00;
  localparam logic [7:0]  RST_LIMIT_MSB      = 8'h00;
  localparam logic [7:0]  RST_LIMIT_LSB      = 8'h04;
  localparam logic [7:0]  RST_CLOCK_CTRL     = 8'h02;
  localparam logic [7:0]  RST_FORWARD_CTRL   = 8'hF0;
  localparam logic [7:0]  CLOCK_CTRL_MASK    = 8'h0F;
  localparam int          OSC_SEL_BIT        = 3;
  localparam int          REF_MODE_BIT       = 2;
  localparam int          RATE_LSB           = 0;
  localparam int          BLOCK_LSB          = 4;
  localparam int          ROUTE_LSB          = 0;
  localparam logic [1:0]  RATE_400M          = 2'h3;
  localparam logic [15:0] FRAME_NUM_ONE      = 16'h0001;
  localparam logic [15:0] FRAME_NUM_ZERO     = 16'h0000;
  typedef enum logic [1:0] {
    VFC_IDLE,
    VFC_IN_FRAME
  } vfc_frame_state_e;
endpackage : vfc_pkg

// ==== rtl/vfc_frame_counter.sv ====
module vfc_frame_counter
  import vfc_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic        rawMode,
  input  wire logic [15:0] frameLimit,
  input  wire logic        frameStart,
  input  wire logic        frameEnd,
  output logic      [15:0] frameNumber,
  output logic             inFrame
);
  vfc_frame_state_e state;
  logic [15:0]      lastNumber;
  logic [15:0]      next_number;

  always_comb begin
    if (frameLimit == FRAME_NUM_ZERO) begin
      next_number = FRAME_NUM_ZERO; // RL7
    end else if (lastNumber >= frameLimit || lastNumber == FRAME_NUM_ZERO) begin
      next_number = FRAME_NUM_ONE; // RL8
    end else begin
      next_number = lastNumber + FRAME_NUM_ONE; // RL8
    end
  end

  // Number is held through the frame so the end packet repeats it
  always_ff @(posedge clock) begin
    if (srst) begin
      state       <= VFC_IDLE;
      lastNumber  <= FRAME_NUM_ZERO;
      frameNumber <= FRAME_NUM_ZERO;
    end else begin
      case (state)
        VFC_IDLE: begin
          if (rawMode && frameStart) begin
            state       <= VFC_IN_FRAME; // RL9
            lastNumber  <= next_number;
            frameNumber <= next_number; // RL6
          end
        end
        VFC_IN_FRAME: begin
          if (frameEnd) begin
            state <= VFC_IDLE; // RL9
          end
        end
        default: begin
          state <= VFC_IDLE;
        end
      endcase
    end
  end

  assign inFrame = (state == VFC_IN_FRAME);
endmodule : vfc_frame_counter

// ==== rtl/vfc_sync_timer.sv ====
module vfc_sync_timer
  import vfc_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic        enable,
  input  wire logic        equalDuty,
  input  wire logic [7:0]  highLsb,
  input  wire logic [7:0]  lowMsb,
  input  wire logic [7:0]  lowLsb,
  output logic             syncPulse
);
  logic [23:0] count;
  logic [23:0] next_reload;

  // Only the low byte of high time is held here, so Hi/Lo high phase is 8 bits
  always_comb begin
    if (equalDuty) begin
      next_reload = {highLsb, lowMsb, lowLsb}; // RL4
    end else if (syncPulse) begin
      // Leaving the high phase, so the low time is loaded next
      next_reload = {8'h00, lowMsb, lowLsb}; // RL3
    end else begin
      next_reload = {16'h0000, highLsb};
    end
  end

  always_ff @(posedge clock) begin
    if (srst || !enable) begin
      count     <= 24'h00_0000;
      syncPulse <= 1'b0;
    end else if (count == 24'h00_0000) begin
      // A reload of V holds the new level for V plus one cycles
      syncPulse <= ~syncPulse; // RL2
      count     <= next_reload;
    end else begin
      count <= count - 24'h00_0001; // RL2
    end
  end
endmodule : vfc_sync_timer

// ==== tb/vfc_assertions.sv ====
module vfc_assertions
  import vfc_pkg::*;
(
  input wire logic        clock,
  input wire logic        srst,
  input wire logic [7:0]  regAddr,
  input wire logic [7:0]  regWriteData,
  input wire logic        regWrite,
  input wire logic        regRead,
  input wire logic [7:0]  regReadData,
  input wire logic        frameStart,
  input wire logic        frameEnd,
  input wire logic [3:0]  inputValid,
  input wire logic [15:0] frameNumber,
  input wire logic        inFrame,
  input wire logic        internalOscillatorSelect,
  input wire logic        referenceHalfRate,
  input wire logic [1:0]  laneRate,
  input wire logic [3:0]  forwardOut0,
  input wire logic [3:0]  forwardOut1
);
  // Only isolated writes are judged; a second write would move the target
  logic ckWr;
  assign ckWr = regWrite && regAddr == ADDR_CLOCK_CTRL;
  default clocking dc @(posedge clock);
  endclocking
  default disable iff (srst);
  property p_rd_idle; !$past(regRead) |-> regReadData == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_rsvd; regRead && regAddr == ADDR_CLOCK_CTRL |=> regReadData[7:4] == 4'h0; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
  property p_osc; ckWr ##1 !ckWr |=> internalOscillatorSelect == $past(regWriteData[3], 2); endproperty
  a_osc: assert property (p_osc) else $error("oscillator select wrong");
  property p_half; ckWr ##1 !ckWr |=> referenceHalfRate == $past(regWriteData[2], 2); endproperty
  a_half: assert property (p_half) else $error("reference mode wrong");
  property p_rate; ckWr ##1 !ckWr |=> laneRate == $past(regWriteData[1:0], 2); endproperty
  a_rate: assert property (p_rate) else $error("lane rate wrong");
  property p_excl; (forwardOut0 & forwardOut1) == 4'h0; endproperty
  a_excl: assert property (p_excl) else $error("input on both outputs");
  property p_src; ((forwardOut0 | forwardOut1) & ~$past(inputValid)) == 4'h0; endproperty
  a_src: assert property (p_src) else $error("forward without valid");
  property p_rise; $rose(inFrame) |-> $past(frameStart, 2); endproperty
  a_rise: assert property (p_rise) else $error("frame began without start");
  property p_fall; $fell(inFrame) |-> $past(frameEnd, 2); endproperty
  a_fall: assert property (p_fall) else $error("frame ended without end");
  property p_hold; $changed(frameNumber) |-> $rose(inFrame); endproperty
  a_hold: assert property (p_hold) else $error("number moved inside frame");
endmodule : vfc_assertions

bind video_forwarding_config_regs vfc_assertions u_vfc_assertions (
  .clock, .srst, .regAddr, .regWriteData, .regWrite, .regRead, .regReadData,
  .frameStart, .frameEnd, .inputValid, .frameNumber, .inFrame,
  .internalOscillatorSelect, .referenceHalfRate, .laneRate, .forwardOut0, .forwardOut1
);

// ==== tb/tb_video_forwarding_config_regs.sv ====
module tb_video_forwarding_config_regs;
  import vfc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock, srst, regWrite, regRead, syncEnable, syncEqualDuty, rawMode;
  logic        frameStart, frameEnd, inFrame, syncPulse, internalOscillatorSelect;
  logic        referenceHalfRate;
  logic [1:0]  laneRate;
  logic [3:0]  inputValid, forwardOut0, forwardOut1;
  logic [7:0]  regAddr, regWriteData, regReadData, v, d;
  logic [15:0] frameNumber;
  logic [7:0]  m [8'h1a:8'h20];
  int          errors, samples_checked, seed, fn, lim, eh, el;
`define CHK(g, e) begin \
  samples_checked++; \
  if ((g) !== (e)) begin \
    errors++; \
    $display("wrong value at %0t: got %0h exp %0h", $time, (g), (e)); \
  end \
end
  video_forwarding_config_regs u_video_forwarding_config_regs (
    .clock, .srst, .regAddr, .regWriteData, .regWrite, .regRead, .regReadData,
    .syncEnable, .syncEqualDuty, .rawMode, .frameStart, .frameEnd, .inputValid,
    .frameNumber, .inFrame, .syncPulse, .internalOscillatorSelect,
    .referenceHalfRate, .laneRate, .forwardOut0, .forwardOut1
  );
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  task automatic tally_and_finish;
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish
  task automatic wr(input logic [7:0] a, input logic [7:0] x);
    @(posedge clock);
    regAddr <= a;
    regWriteData <= x;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
    if (a >= 8'h1a && a <= 8'h20) m[a] = (a == ADDR_CLOCK_CTRL) ? (x & CLOCK_CTRL_MASK) : x;
  endtask : wr
  task automatic rdc(input logic [7:0] a);
    @(posedge clock);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    #1;
    `CHK(regReadData, (a >= 8'h1a && a <= 8'h20) ? m[a] : 8'h00)
  endtask : rdc
  // Times one sync phase; a negative expectation only resynchronises
  task automatic phase(input logic lv, input int ex);
    int n;
    n = 0;
    while (syncPulse !== lv && n < 1000) begin
      @(posedge clock);
      #1;
      n++;
    end
    if (n >= 1000) begin
      errors++;
      $display("wrong value at %0t: sync level never reached", $time);
      return;
    end
    n = 0;
    while (syncPulse === lv && n < 1000) begin
      @(posedge clock);
      #1;
      n++;
    end
    if (n >= 1000) begin
      errors++;
      $display("wrong value at %0t: sync level never left", $time);
    end else if (ex >= 0) begin
      `CHK(n, ex)
    end
  endtask : phase
  // A second start inside the frame must be ignored
  task automatic frame;
    @(posedge clock);
    frameStart <= 1'b1;
    @(posedge clock);
    frameStart <= 1'b0;
    fn = (lim == 0) ? 0 : ((fn >= lim) ? 1 : fn + 1);
    @(posedge clock);
    frameStart <= 1'b1;
    @(posedge clock);
    frameStart <= 1'b0;
    #1;
    `CHK(frameNumber, fn[15:0])
    `CHK(inFrame, 1'b1)
    @(posedge clock);
    frameEnd <= 1'b1;
    @(posedge clock);
    frameEnd <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
    `CHK(frameNumber, fn[15:0])
    `CHK(inFrame, 1'b0)
  endtask : frame
  initial begin
    seed = 32'h0000_125e;
    {srst, regWrite, regRead, regAddr, regWriteData} = {1'b1, 18'h0_0000};
    {syncEnable, syncEqualDuty, rawMode, frameStart, frameEnd, inputValid} = 9'h000;
    m = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h04, 8'h02, 8'hf0};
    repeat (12) @(posedge clock);
    srst <= 1'b0;
    #1;
    `CHK({internalOscillatorSelect, referenceHalfRate, laneRate}, 4'h2)
    for (int a = 8'h19; a <= 8'h21; a++) rdc(a[7:0]);
    for (int a = 8'h19; a <= 8'h21; a++) begin
      v = 8'($random(seed));
      if (a == ADDR_CLOCK_CTRL && v[1:0] == RATE_400M) v[REF_MODE_BIT] = 1'b0;
      wr(a[7:0], v);
      rdc(a[7:0]);
    end
    for (int i = 0; i < 16; i++) begin
      if (i[2] && i[1:0] == 2'h3) continue;
      v = 8'($random(seed));
      wr(ADDR_CLOCK_CTRL, {v[7:4], i[3:0]});
      @(posedge clock);
      #1;
      `CHK({internalOscillatorSelect, referenceHalfRate, laneRate}, m[8'h1f][3:0])
    end
    for (int i = 0; i < 48; i++) begin
      if (i % 8 == 0) begin
        v = 8'($random(seed));
        wr(ADDR_FORWARD_CTRL, {4'hf, m[8'h20][3:0]});
        wr(ADDR_FORWARD_CTRL, v);
      end
      d = 8'($random(seed));
      @(posedge clock);
      inputValid <= d[3:0];
      @(posedge clock);
      #1;
      `CHK(forwardOut0, d[3:0] & ~m[8'h20][7:4] & ~m[8'h20][3:0])
      `CHK(forwardOut1, d[3:0] & ~m[8'h20][7:4] & m[8'h20][3:0])
    end
    @(posedge clock);
    rawMode <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      lim = (k == 0) ? 3 : ((k == 1) ? 258 : 0);
      wr(ADDR_LIMIT_MSB, 8'(lim >> 8));
      wr(ADDR_LIMIT_LSB, 8'(lim));
      repeat ((k == 0) ? 7 : ((k == 1) ? 259 : 2)) frame();
    end
    @(posedge clock);
    syncEnable <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      wr(ADDR_SYNC_HIGH_LSB, (k == 0) ? 8'h01 : 8'h00);
      wr(ADDR_SYNC_LOW_MSB, (k == 1) ? 8'h00 : 8'h01);
      wr(ADDR_SYNC_LOW_LSB, (k == 1) ? 8'h00 : 8'h02);
      @(posedge clock);
      syncEqualDuty <= (k == 2);
      eh = (k == 2) ? int'({m[8'h1a], m[8'h1b], m[8'h1c]}) + 1 : int'(m[8'h1a]) + 1;
      el = (k == 2) ? eh : int'({m[8'h1b], m[8'h1c]}) + 1;
      phase(1'b1, -1);
      phase(1'b0, -1);
      phase(1'b1, eh);
      phase(1'b0, el);
    end
    // Mid-run reset must bring every register back to its reset value
    @(posedge clock);
    srst <= 1'b1;
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    m = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h04, 8'h02, 8'hf0};
    #1;
    `CHK({internalOscillatorSelect, referenceHalfRate, laneRate}, 4'h2)
    `CHK({forwardOut0, forwardOut1}, 8'h00)
    for (int a = 8'h1a; a <= 8'h20; a++) rdc(a[7:0]);
    tally_and_finish();
  end
endmodule : tb_video_forwarding_config_regs
